// ---- rtl/rate_diag_pkg.sv ----
// shared constants and types for the port 1 rate limit and cable diagnostic registers
package rate_diag_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CODE_W = 7;
	localparam int EVT_W  = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_INGRESS_RATE_P32 = 8'h76;
	localparam logic [ADDR_W-1:0] OFS_EGRESS_RATE_P10  = 8'h78;
	localparam logic [ADDR_W-1:0] OFS_EGRESS_RATE_P32  = 8'h7a;
	localparam logic [ADDR_W-1:0] OFS_PHY_CABLE_DIAG   = 8'h7c;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS     = 8'h80;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK       = 8'h82;

	// field positions
	localparam int HI_CODE_LSB       = 8;
	localparam int LO_CODE_LSB       = 0;
	localparam int EGRESS_ENABLE_BIT = 7;
	localparam int TEST_START_BIT    = 12;
	localparam int FORCE_LINK_BIT    = 11;
	localparam int DIAG_RSVD_BIT     = 10;
	localparam int LOOPBACK_BIT      = 9;
	localparam int FAULT_COUNT_W     = 9;
	localparam int EVT_TEST_DONE     = 0;
	localparam int EVT_FAULT_FOUND   = 1;

	// reset values
	localparam logic [DATA_W-1:0] RATE_REG_RESET   = 16'h0000;
	localparam logic              DIAG_RSVD_RESET  = 1'h1;
	localparam logic [EVT_W-1:0]  EVENT_REG_RESET  = 2'h0;
	localparam logic [FAULT_COUNT_W-1:0] FAULT_COUNT_RESET = 9'h000;

	// rate code map
	typedef logic [16:0] kbps_type;
	localparam logic [CODE_W-1:0] CODE_NO_LIMIT     = 7'h00;
	localparam logic [CODE_W-1:0] CODE_MBPS_MAX_100 = 7'h64;
	localparam logic [CODE_W-1:0] CODE_MBPS_MAX_10  = 7'h0a;
	localparam logic [CODE_W-1:0] CODE_KBPS_BASE    = 7'h64;
	localparam logic [CODE_W-1:0] CODE_KBPS_FIRST   = 7'h65;
	localparam logic [CODE_W-1:0] CODE_KBPS_LAST    = 7'h73;
	localparam kbps_type KBPS_PER_MBPS = 17'h003e8;
	localparam kbps_type KBPS_STEP     = 17'h00040;
	localparam kbps_type LINE_100_KBPS = 17'h186a0;
	localparam kbps_type LINE_10_KBPS  = 17'h02710;

	// timing
	localparam int CLK_HZ                    = 20_000_000;
	localparam int CABLE_TEST_TIMEOUT_MS     = 100;
	localparam int CABLE_TEST_TIMEOUT_CYCLES = CABLE_TEST_TIMEOUT_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		OUTCOME_NORMAL = 2'b00,
		OUTCOME_OPEN   = 2'b01,
		OUTCOME_SHORT  = 2'b10,
		OUTCOME_FAILED = 2'b11
	} cable_outcome_type;

	typedef enum logic [0:0] {
		TEST_IDLE = 1'b0,
		TEST_RUN  = 1'b1
	} test_state_type;

	typedef enum logic [2:0] {
		SEL_NONE      = 3'b000,
		SEL_INGRESS   = 3'b001,
		SEL_EGRESS_LO = 3'b010,
		SEL_EGRESS_HI = 3'b011,
		SEL_DIAG      = 3'b100,
		SEL_STATUS    = 3'b101,
		SEL_MASK      = 3'b110
	} reg_sel_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} host_req_type;

	typedef struct packed {
		logic                     done;
		cable_outcome_type        outcome;
		logic                     near_short;
		logic [FAULT_COUNT_W-1:0] fault_count;
	} phy_result_type;

	typedef struct packed {
		logic     limit_on;
		kbps_type rate_kbps;
	} rate_cfg_type;
endpackage

// ---- rtl/rate_code_decoder.sv ----
// rate code to kb/s limit decoder for one priority and direction
`timescale 1ns/1ns
module rate_code_decoder (
	input  wire logic [rate_diag_pkg::CODE_W-1:0] code,
	input  wire logic                             speed_100,
	input  wire logic                             enable,
	output rate_diag_pkg::rate_cfg_type           cfg
);
	import rate_diag_pkg::*;

	logic [CODE_W-1:0] mbps_max;

	assign mbps_max = speed_100 ? CODE_MBPS_MAX_100 : CODE_MBPS_MAX_10;

	always_comb begin
		cfg.limit_on  = 1'b0;
		cfg.rate_kbps = speed_100 ? LINE_100_KBPS : LINE_10_KBPS;
		if (!enable) begin
			cfg.limit_on = 1'b0;
		end else if (code >= CODE_KBPS_FIRST && code <= CODE_KBPS_LAST) begin
			cfg.limit_on  = 1'b1;
			cfg.rate_kbps = KBPS_STEP * kbps_type'(code - CODE_KBPS_BASE);
		end else if (code != CODE_NO_LIMIT && code <= mbps_max) begin
			cfg.limit_on  = 1'b1;
			cfg.rate_kbps = KBPS_PER_MBPS * kbps_type'(code);
		end
		// codes beyond the map for this speed fall back to line rate
	end
endmodule // rate_code_decoder

// ---- rtl/cable_test_watchdog.sv ----
// watchdog that ends a cable test the PHY never answers
`timescale 1ns/1ns
module cable_test_watchdog #(
	parameter int TIMEOUT_CYCLES = rate_diag_pkg::CABLE_TEST_TIMEOUT_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic run,
	output logic      expired
);
	localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

	logic [CW-1:0] count;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count   <= '0;
			expired <= 1'b0;
		end else if (ce) begin
			expired <= 1'b0;
			if (!run) begin
				count <= '0;
			end else if (count == CW'(TIMEOUT_CYCLES - 1)) begin
				count   <= '0;
				expired <= 1'b1;
			end else begin
				count <= count + 1'b1;
			end
		end
	end
endmodule // cable_test_watchdog

// ---- rtl/port1_rate_limit_cable_diag_regs.sv ----
// port 1 rate limit and cable diagnostic register bank with event interrupt
`timescale 1ns/1ns
module port1_rate_limit_cable_diag_regs #(
	parameter int TEST_TIMEOUT_CYCLES = rate_diag_pkg::CABLE_TEST_TIMEOUT_CYCLES
) (
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire logic                              ce,
	input  rate_diag_pkg::host_req_type            host_req,
	output logic [rate_diag_pkg::DATA_W-1:0]       rdata,
	input  wire logic                              port1_speed_100,
	input  rate_diag_pkg::phy_result_type          phy_result,
	output logic                                   cable_test_run,
	output logic                                   force_link_pass,
	output logic                                   near_end_loopback,
	output rate_diag_pkg::rate_cfg_type [1:0]      ingress_cfg,
	output rate_diag_pkg::rate_cfg_type [3:0]      egress_cfg,
	output logic                                   irq
);
	import rate_diag_pkg::*;

	logic [DATA_W-1:0]        ingress_rate_prio3_prio2;
	logic [DATA_W-1:0]        egress_rate_prio1_prio0;
	logic [DATA_W-1:0]        egress_rate_prio3_prio2;
	logic                     diag_reserved;
	logic                     near_short_flag;
	cable_outcome_type        cable_test_outcome;
	logic [FAULT_COUNT_W-1:0] fault_distance_count;
	test_state_type           test_state;
	logic [EVT_W-1:0]         event_status;
	logic [EVT_W-1:0]         event_mask;
	logic [EVT_W-1:0]         next_event_status;
	logic [EVT_W-1:0]         next_event_mask;
	logic [EVT_W-1:0]         events;
	reg_sel_type              sel;
	logic                     wr_any;
	logic                     cable_test_start;
	logic                     start_test;
	logic                     test_finish;
	logic                     watchdog_expired;
	cable_outcome_type        finish_outcome;
	logic [DATA_W-1:0]        diag_word;
	logic [DATA_W-1:0]        read_word;
	logic [5:0][CODE_W-1:0]   codes;
	logic [5:0]               dir_enable;
	rate_cfg_type [5:0]       decoded;

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	always_comb begin
		if (host_req.addr == OFS_INGRESS_RATE_P32) begin
			sel = SEL_INGRESS;
		end else if (host_req.addr == OFS_EGRESS_RATE_P10) begin
			sel = SEL_EGRESS_LO;
		end else if (host_req.addr == OFS_EGRESS_RATE_P32) begin
			sel = SEL_EGRESS_HI;
		end else if (host_req.addr == OFS_PHY_CABLE_DIAG) begin
			sel = SEL_DIAG;
		end else if (host_req.addr == OFS_EVENT_STATUS) begin
			sel = SEL_STATUS;
		end else if (host_req.addr == OFS_EVENT_MASK) begin
			sel = SEL_MASK;
		end else begin
			sel = SEL_NONE;
		end
	end

	assign wr_any = ce && host_req.wr;

	////////////////////////////////////////////////////////////////////////////////
	// rate code registers

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ingress_rate_prio3_prio2 <= RATE_REG_RESET;
		end else if (wr_any && sel == SEL_INGRESS) begin
			ingress_rate_prio3_prio2 <= host_req.wdata;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			egress_rate_prio1_prio0 <= RATE_REG_RESET;
		end else if (wr_any && sel == SEL_EGRESS_LO) begin
			egress_rate_prio1_prio0 <= host_req.wdata;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			egress_rate_prio3_prio2 <= RATE_REG_RESET;
		end else if (wr_any && sel == SEL_EGRESS_HI) begin
			egress_rate_prio3_prio2 <= host_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per priority decode, ingress in 1:0 and egress in 5:2

	assign codes[0] = ingress_rate_prio3_prio2[LO_CODE_LSB +: CODE_W];
	assign codes[1] = ingress_rate_prio3_prio2[HI_CODE_LSB +: CODE_W];
	assign codes[2] = egress_rate_prio1_prio0[LO_CODE_LSB +: CODE_W];
	assign codes[3] = egress_rate_prio1_prio0[HI_CODE_LSB +: CODE_W];
	assign codes[4] = egress_rate_prio3_prio2[LO_CODE_LSB +: CODE_W];
	assign codes[5] = egress_rate_prio3_prio2[HI_CODE_LSB +: CODE_W];

	// ingress has no enable bit of its own here, so it is always armed
	assign dir_enable = {{4{egress_rate_prio1_prio0[EGRESS_ENABLE_BIT]}}, 2'h3};

	for (genvar i = 0; i < 6; i++) begin : g_dec
		rate_code_decoder u_dec (
			.code      (codes[i]),
			.speed_100 (port1_speed_100),
			.enable    (dir_enable[i]),
			.cfg       (decoded[i])
		);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ingress_cfg <= '0;
			egress_cfg  <= '0;
		end else if (ce) begin
			ingress_cfg <= decoded[1:0];
			egress_cfg  <= decoded[5:2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// diagnostic controls

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			force_link_pass   <= 1'b0;
			diag_reserved     <= DIAG_RSVD_RESET;
			near_end_loopback <= 1'b0;
		end else if (wr_any && sel == SEL_DIAG) begin
			force_link_pass   <= host_req.wdata[FORCE_LINK_BIT];
			diag_reserved     <= host_req.wdata[DIAG_RSVD_BIT];
			near_end_loopback <= host_req.wdata[LOOPBACK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// cable test sequencer

	// a start while a test runs is ignored; a zero write cannot abort
	assign start_test = host_req.wr && sel == SEL_DIAG && host_req.wdata[TEST_START_BIT]
		&& test_state == TEST_IDLE;
	assign test_finish = test_state == TEST_RUN && (phy_result.done || watchdog_expired);
	assign cable_test_start = test_state == TEST_RUN;

	cable_test_watchdog #(
		.TIMEOUT_CYCLES (TEST_TIMEOUT_CYCLES)
	) u_watchdog (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.run     (cable_test_run),
		.expired (watchdog_expired)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			test_state     <= TEST_IDLE;
			cable_test_run <= 1'b0;
		end else if (ce) begin
			case (test_state)
				TEST_IDLE: begin
					if (start_test) begin
						test_state     <= TEST_RUN;
						cable_test_run <= 1'b1;
					end
				end
				TEST_RUN: begin
					if (test_finish) begin
						test_state     <= TEST_IDLE;
						cable_test_run <= 1'b0;
					end
				end
				default: begin
					test_state     <= TEST_IDLE;
					cable_test_run <= 1'b0;
				end
			endcase
		end
	end

	// a PHY answer in the timeout cycle still counts as the result
	assign finish_outcome = phy_result.done ? phy_result.outcome : OUTCOME_FAILED;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			near_short_flag      <= 1'b0;
			cable_test_outcome   <= OUTCOME_NORMAL;
			fault_distance_count <= FAULT_COUNT_RESET;
		end else if (ce && test_finish) begin
			cable_test_outcome   <= finish_outcome;
			near_short_flag      <= phy_result.done && phy_result.near_short
				&& phy_result.outcome == OUTCOME_SHORT;
			fault_distance_count <= phy_result.done ? phy_result.fault_count
				: FAULT_COUNT_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// events and interrupt

	assign events[EVT_TEST_DONE]   = test_finish;
	assign events[EVT_FAULT_FOUND] = test_finish && finish_outcome != OUTCOME_NORMAL;

	// set beats the read clear so an event in the read cycle survives
	always_comb begin
		next_event_status = event_status;
		if (host_req.rd && sel == SEL_STATUS) begin
			next_event_status = '0;
		end
		next_event_status = next_event_status | events;
	end

	assign next_event_mask = (host_req.wr && sel == SEL_MASK) ? host_req.wdata[EVT_W-1:0]
		: event_mask;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			event_status <= EVENT_REG_RESET;
			event_mask   <= EVENT_REG_RESET;
			irq          <= 1'b0;
		end else if (ce) begin
			event_status <= next_event_status;
			event_mask   <= next_event_mask;
			irq          <= |(next_event_status & next_event_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	assign diag_word = {near_short_flag, cable_test_outcome, cable_test_start, force_link_pass,
		diag_reserved, near_end_loopback, fault_distance_count};

	always_comb begin
		case (sel)
			SEL_INGRESS:   read_word = ingress_rate_prio3_prio2;
			SEL_EGRESS_LO: read_word = egress_rate_prio1_prio0;
			SEL_EGRESS_HI: read_word = egress_rate_prio3_prio2;
			SEL_DIAG:      read_word = diag_word;
			SEL_STATUS:    read_word = {{(DATA_W - EVT_W){1'b0}}, event_status};
			SEL_MASK:      read_word = {{(DATA_W - EVT_W){1'b0}}, event_mask};
			default:       read_word = '0;
		endcase
	end

	// data stands for exactly the cycle after the read strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (ce) begin
			rdata <= host_req.rd ? read_word : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_prio3_zero_full_rate;
		@(posedge ref_clk) disable iff (rst)
		ce && codes[1] == CODE_NO_LIMIT |=> !ingress_cfg[1].limit_on;
	endproperty
	a_prio3_zero_full_rate: assert property (p_prio3_zero_full_rate)
		else $error("zero ingress priority 3 code still limits");

	property p_prio2_ten_mbps;
		@(posedge ref_clk) disable iff (rst)
		ce && codes[0] == CODE_MBPS_MAX_10 && !port1_speed_100
		|=> ingress_cfg[0].limit_on && ingress_cfg[0].rate_kbps == LINE_10_KBPS;
	endproperty
	a_prio2_ten_mbps: assert property (p_prio2_ten_mbps)
		else $error("ingress priority 2 code 10 not decoded at 10 Mb/s");

	property p_prio1_hundred;
		@(posedge ref_clk) disable iff (rst)
		ce && codes[3] == CODE_MBPS_MAX_100 && port1_speed_100 && dir_enable[3]
		|=> egress_cfg[1].limit_on && egress_cfg[1].rate_kbps == LINE_100_KBPS;
	endproperty
	a_prio1_hundred: assert property (p_prio1_hundred)
		else $error("egress priority 1 code 100 not decoded");

	property p_egress_disabled;
		@(posedge ref_clk) disable iff (rst)
		ce && !egress_rate_prio1_prio0[EGRESS_ENABLE_BIT]
		|=> !egress_cfg[0].limit_on && !egress_cfg[1].limit_on
			&& !egress_cfg[2].limit_on && !egress_cfg[3].limit_on;
	endproperty
	a_egress_disabled: assert property (p_egress_disabled)
		else $error("egress limits active while disabled");

	property p_prio0_kbps_step;
		@(posedge ref_clk) disable iff (rst)
		ce && codes[2] == CODE_KBPS_FIRST && dir_enable[2]
		|=> egress_cfg[0].limit_on && egress_cfg[0].rate_kbps == KBPS_STEP;
	endproperty
	a_prio0_kbps_step: assert property (p_prio0_kbps_step)
		else $error("egress priority 0 code 0x65 not 64 kb/s");

	property p_prio3_kbps_last;
		@(posedge ref_clk) disable iff (rst)
		ce && codes[5] == CODE_KBPS_LAST && dir_enable[5]
		|=> egress_cfg[3].rate_kbps == 17'h003c0;
	endproperty
	a_prio3_kbps_last: assert property (p_prio3_kbps_last)
		else $error("egress priority 3 code 0x73 not 960 kb/s");

	property p_start_runs;
		@(posedge ref_clk) disable iff (rst)
		ce && start_test |=> cable_test_run && diag_word[TEST_START_BIT];
	endproperty
	a_start_runs: assert property (p_start_runs)
		else $error("cable test did not start");

	property p_finish_clears;
		@(posedge ref_clk) disable iff (rst)
		ce && test_finish |=> !cable_test_run && !diag_word[TEST_START_BIT]
			&& event_status[EVT_TEST_DONE];
	endproperty
	a_finish_clears: assert property (p_finish_clears)
		else $error("start bit not self cleared at test end");

	property p_timeout_fails;
		@(posedge ref_clk) disable iff (rst)
		ce && test_state == TEST_RUN && watchdog_expired && !phy_result.done
		|=> cable_test_outcome == OUTCOME_FAILED && fault_distance_count == FAULT_COUNT_RESET;
	endproperty
	a_timeout_fails: assert property (p_timeout_fails)
		else $error("timed out test not reported failed");

	property p_result_captured;
		@(posedge ref_clk) disable iff (rst)
		ce && test_state == TEST_RUN && phy_result.done
		|=> fault_distance_count == $past(phy_result.fault_count)
			&& cable_test_outcome == $past(phy_result.outcome);
	endproperty
	a_result_captured: assert property (p_result_captured)
		else $error("cable test result not captured");

	property p_near_short_only_short;
		@(posedge ref_clk) disable iff (rst)
		near_short_flag |-> cable_test_outcome == OUTCOME_SHORT;
	endproperty
	a_near_short_only_short: assert property (p_near_short_only_short)
		else $error("near short flag without short outcome");

	property p_force_link;
		@(posedge ref_clk) disable iff (rst)
		wr_any && sel == SEL_DIAG
		|=> force_link_pass == $past(host_req.wdata[FORCE_LINK_BIT])
			&& near_end_loopback == $past(host_req.wdata[LOOPBACK_BIT]);
	endproperty
	a_force_link: assert property (p_force_link)
		else $error("force link or loopback not taken");

	property p_irq_level;
		@(posedge ref_clk) disable iff (rst)
		irq == |(event_status & event_mask);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt does not follow masked status");
endmodule // port1_rate_limit_cable_diag_regs

// ---- dv/cable_tester_model.sv ----
// stand-in for the port 1 PHY cable tester that answers a running test
`timescale 1ns/1ns
module cable_tester_model (
	input  wire logic                                    ref_clk,
	input  wire logic                                    rst,
	input  wire logic                                    cable_test_run,
	input  wire logic                                    answer,
	input  wire logic [7:0]                              delay,
	input  rate_diag_pkg::cable_outcome_type             outcome,
	input  wire logic [rate_diag_pkg::FAULT_COUNT_W-1:0] count,
	output rate_diag_pkg::phy_result_type                phy_result
);
	import rate_diag_pkg::*;
	logic [7:0] waited;
	////////////////////////////////////////////////////////////////
	// answer is withheld when told to, so the watchdog path gets exercised
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waited     <= 8'h00;
			phy_result <= '0;
		end else if (cable_test_run && answer && waited == delay) begin
			waited     <= waited + 8'h01;
			phy_result <= {1'b1, outcome, 1'b1, count};
		end else begin
			waited     <= cable_test_run ? waited + 8'h01 : 8'h00;
			// fields mean nothing outside a result, so never repeat them
			phy_result <= {1'b0, ~phy_result[11:0]};
		end
	end
endmodule // cable_tester_model

// ---- dv/tb.sv ----
// self-checking bench for the port 1 rate limit and cable diagnostic registers
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb;
	import rate_diag_pkg::*;
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              spd = 1'b1;
	logic              ce = 1'b1;
	host_req_type      host_req = '0;
	logic [DATA_W-1:0] rdata;
	phy_result_type    phy_result;
	logic              run, force_link, loopback, irq;
	rate_cfg_type      [1:0] ingress_cfg;
	rate_cfg_type      [3:0] egress_cfg;
	logic              answer = 1'b0;
	logic [7:0]        delay = 8'h04;
	cable_outcome_type outcome = OUTCOME_NORMAL;
	logic [8:0]        count = 9'h000;
	logic              rd_seen = 1'b0;
	logic [15:0]       exp_q[$];
	logic [15:0]       want;
	logic [15:0]       rv[3] = '{16'h0000, 16'h0000, 16'h0000};
	logic [15:0]       diag_res = 16'h0000;
	logic [6:0]        codes[8] = '{7'h00, 7'h01, 7'h0a, 7'h0b, 7'h64, 7'h65, 7'h73, 7'h74};
	int                err_total = 0;
	int                checks = 0;

	always #25 ref_clk = ~ref_clk;

	port1_rate_limit_cable_diag_regs #(.TEST_TIMEOUT_CYCLES(20)) port1_rate_limit_cable_diag_regs_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.host_req(host_req),
		.rdata(rdata),
		.port1_speed_100(spd),
		.phy_result(phy_result),
		.cable_test_run(run),
		.force_link_pass(force_link),
		.near_end_loopback(loopback),
		.ingress_cfg(ingress_cfg),
		.egress_cfg(egress_cfg),
		.irq(irq)
	);
	cable_tester_model cable_tester_model_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.cable_test_run(run),
		.answer(answer),
		.delay(delay),
		.outcome(outcome),
		.count(count),
		.phy_result(phy_result)
	);
	////////////////////////////////////////////////////////////////
	// read data stand only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_seen) begin
			want = exp_q.pop_front();
			`CHK(rdata, want)
		end
		rd_seen <= host_req.rd;
	end
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		host_req.wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [15:0] d);
		exp_q.push_back(d);
		host_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		host_req.rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	function automatic rate_cfg_type exp_cfg(logic [6:0] c, logic s, logic en);
		rate_cfg_type r;
		r = '{limit_on: 1'b0, rate_kbps: s ? LINE_100_KBPS : LINE_10_KBPS};
		if (en && c >= CODE_KBPS_FIRST && c <= CODE_KBPS_LAST)
			r = '{1'b1, kbps_type'(c - CODE_KBPS_BASE) * KBPS_STEP};
		else if (en && c != CODE_NO_LIMIT && c <= (s ? CODE_MBPS_MAX_100 : CODE_MBPS_MAX_10))
			r = '{1'b1, kbps_type'(c) * KBPS_PER_MBPS};
		return r;
	endfunction

	task automatic chk_cfg();
		`CHK(ingress_cfg[1], exp_cfg(rv[0][14:8], spd, 1'b1))
		`CHK(ingress_cfg[0], exp_cfg(rv[0][6:0], spd, 1'b1))
		`CHK(egress_cfg[1], exp_cfg(rv[1][14:8], spd, rv[1][7]))
		`CHK(egress_cfg[0], exp_cfg(rv[1][6:0], spd, rv[1][7]))
		`CHK(egress_cfg[3], exp_cfg(rv[2][14:8], spd, rv[1][7]))
		`CHK(egress_cfg[2], exp_cfg(rv[2][6:0], spd, rv[1][7]))
	endtask

	task automatic cable_test(input logic ans, input cable_outcome_type oc, input logic [8:0] cnt);
		int n;
		logic [1:0] m;
		m = 2'($urandom);
		answer <= ans;
		outcome <= oc;
		count <= cnt;
		delay <= 8'h04 + 8'($urandom % 10);
		wr_reg(OFS_EVENT_MASK, {14'h0000, m});
		wr_reg(OFS_PHY_CABLE_DIAG, 16'h1a00);
		`CHK(run, 1'b1)
		// a zero start bit must not cut the test short
		wr_reg(OFS_PHY_CABLE_DIAG, 16'h0a00);
		rd_reg(OFS_PHY_CABLE_DIAG, diag_res | 16'h1a00);
		n = 0;
		while (run === 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 200) begin
			err_total++;
			give_verdict();
		end
		if (!ans) begin
			oc = OUTCOME_FAILED;
			cnt = 9'h000;
		end
		diag_res = {oc == OUTCOME_SHORT, oc, 4'h0, cnt};
		@(negedge ref_clk);
		`CHK(irq, |(m & {oc != OUTCOME_NORMAL, 1'b1}))
		@(posedge ref_clk);
		rd_reg(OFS_PHY_CABLE_DIAG, diag_res | 16'h0a00);
		rd_reg(OFS_EVENT_STATUS, {14'h0000, oc != OUTCOME_NORMAL, 1'b1});
		rd_reg(OFS_EVENT_STATUS, 16'h0000);
		`CHK(irq, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int n;
		int k;
		void'($urandom(15546));
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk_cfg();
		@(posedge ref_clk);
		for (n = 0; n < 3; n++)
			rd_reg(OFS_INGRESS_RATE_P32 + 8'(2 * n), 16'h0000);
		rd_reg(OFS_PHY_CABLE_DIAG, 16'h0400);
		rd_reg(OFS_EVENT_STATUS, 16'h0000);
		rd_reg(OFS_EVENT_MASK, 16'h0000);
		wr_reg(8'h84, 16'hffff);
		rd_reg(8'h84, 16'h0000);
		rd_reg(8'h77, 16'h0000);
		// boundary codes of every class at both line rates
		for (n = 0; n < 16; n++) begin
			spd <= n[3];
			rv[0] = {1'b0, codes[n[2:0]], 1'b0, codes[7 - n[2:0]]};
			wr_reg(OFS_INGRESS_RATE_P32, rv[0]);
			@(negedge ref_clk);
			chk_cfg();
			@(posedge ref_clk);
		end
		for (n = 0; n < 12; n++) begin
			spd <= 1'($urandom);
			for (k = 0; k < 3; k++) begin
				rv[k] = 16'($urandom);
				wr_reg(OFS_INGRESS_RATE_P32 + 8'(2 * k), rv[k]);
			end
			@(negedge ref_clk);
			chk_cfg();
			@(posedge ref_clk);
			for (k = 0; k < 3; k++)
				rd_reg(OFS_INGRESS_RATE_P32 + 8'(2 * k), rv[k]);
		end
		// a low enable must freeze the registers against a write
		ce <= 1'b0;
		wr_reg(OFS_INGRESS_RATE_P32, ~rv[0]);
		ce <= 1'b1;
		rd_reg(OFS_INGRESS_RATE_P32, rv[0]);
		// read only fields must shrug off writes
		wr_reg(OFS_PHY_CABLE_DIAG, 16'heaff);
		@(negedge ref_clk);
		`CHK(force_link, 1'b1)
		`CHK(loopback, 1'b1)
		@(posedge ref_clk);
		rd_reg(OFS_PHY_CABLE_DIAG, 16'h0a00);
		wr_reg(OFS_PHY_CABLE_DIAG, 16'h0000);
		@(negedge ref_clk);
		`CHK(force_link, 1'b0)
		`CHK(loopback, 1'b0)
		@(posedge ref_clk);
		for (n = 0; n < 4; n++)
			cable_test(1'b1, cable_outcome_type'(n), 9'($urandom));
		cable_test(1'b0, OUTCOME_NORMAL, 9'h000);
		repeat (3) @(posedge ref_clk);
		`CHK(exp_q.size(), 0)
		give_verdict();
	end
endmodule // tb
